// ### line_out_pkg.sv
/*
  Constants shared by the line-output routing and status register bank:
  register indices, field positions, reset values, bus sizes and timing.
  Assumes a 10 MHz system clock; nothing else is needed from outside.
*/
package line_out_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [6:0] IDX_LEFT_LINE_OUT_LEVEL      = 7'h56;
  localparam logic [6:0] IDX_RESERVED_A               = 7'h57;
  localparam logic [6:0] IDX_LEFT_GAIN_TO_RIGHT_LINE  = 7'h58;
  localparam logic [6:0] IDX_LEFT_DAC_TO_RIGHT_LINE   = 7'h59;
  localparam logic [6:0] IDX_RESERVED_B               = 7'h5a;
  localparam logic [6:0] IDX_RIGHT_GAIN_TO_RIGHT_LINE = 7'h5b;
  localparam logic [6:0] IDX_RIGHT_DAC_TO_RIGHT_LINE  = 7'h5c;
  localparam logic [6:0] IDX_RIGHT_LINE_OUT_LEVEL     = 7'h5d;
  localparam logic [6:0] IDX_MODULE_POWER_STATUS      = 7'h5e;
  localparam logic [6:0] IDX_DRIVER_SHORT_STATUS      = 7'h5f;
  localparam logic [6:0] IDX_IRQ_STATUS               = 7'h60;
  localparam logic [6:0] IDX_IRQ_MASK                 = 7'h61;

  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;

  // Output level register fields
  localparam int LEVEL_MSB  = 7;
  localparam int LEVEL_LSB  = 4;
  localparam int MUTE_BIT   = 3;
  localparam int RSVD_BIT   = 2;
  localparam int PEND_BIT   = 1;
  localparam int POWER_BIT  = 0;
  localparam logic [3:0] LEVEL_MAX = 4'h9;

  // Route register fields
  localparam int ROUTE_BIT  = 7;
  localparam int VOL_MSB    = 6;

  // Route slots in the route array
  localparam int SLOT_LEFT_GAIN  = 0;
  localparam int SLOT_LEFT_DAC   = 1;
  localparam int SLOT_RIGHT_GAIN = 2;
  localparam int SLOT_RIGHT_DAC  = 3;

  // Interrupt status bits: short circuits 7..4, gain settled 1..0
  localparam int IRQ_SHORT_LSB   = 4;
  localparam int IRQ_LEFT_DONE   = 1;
  localparam int IRQ_RIGHT_DONE  = 0;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic       RESET_PEND = 1'b1;

  // Gain ramp: one level step per interval
  localparam int CLK_HZ        = 10_000_000;
  localparam int STEP_TIME_NS  = 10_000;
  localparam int STEP_CYCLES   = (STEP_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  localparam int SYNC_W = 12;

endpackage

// ### status_sync.sv
/*
  Two-flop synchroniser bank for the analog status levels.
  Assumes inputs are slow levels; the first stage is read only by the second.
*/
module status_sync #(
  parameter int W = 12
) (
  input  wire logic         i_clk,      // System clock
  input  wire logic         i_reset_n,  // Synchronous reset, active low
  input  wire logic [W-1:0] i_async,    // Levels from outside the domain
  output logic      [W-1:0] o_sync      // Synchronised levels
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t state_ff;
  sync_state_t nxt_state;

  always_comb begin
    nxt_state        = state_ff;
    nxt_state.meta   = i_async;
    nxt_state.stable = state_ff.meta;
    if (!i_reset_n) begin
      nxt_state = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    state_ff <= nxt_state;
  end

  assign o_sync = state_ff.stable;

endmodule

// ### line_out_routing_status_regs.sv
/*
  Line-output level, mute, power and right-line routing registers, plus
  read-only module power and driver short-circuit status, on an Avalon-MM
  slave with waitrequest. Status levels come from the analog side and are
  synchronised here. Each register sits in the low byte of one 32-bit word.
*/
// Register access over Avalon-MM was left to the implementer.
// Functional notes
// - Bits 7..4 of each level register set line output gain, codes 0-9, reset 0; writes of codes 10-15 are stored and ramped to as well.
// - Bit 3 of each level register unmutes when one; reset keeps output muted.
// - Bit 1 reads one while programmed gains are pending; resets to one; read-only.
// - Bit 0 of each level register is writable power-up state, reset zero.
// - Bit 7 of each route register connects that source to the right line output.
// - Bits 6..0 of each route register hold a 7-bit volume code, reset zero.
// - Power status shows DACs, line outputs and headphone drivers powered up.
// - Short status bits 7..4 show shorts on four headphone drivers.
// - Short status bits 3..2 show headphone common drivers powered up.
module line_out_routing_status_regs #(
  parameter int STEP_CYCLES = line_out_pkg::STEP_CYCLES
) (
  input  wire logic                            i_clk,                // System clock, 10 MHz
  input  wire logic                            i_reset_n,            // Synchronous reset, active low
  input  wire logic [line_out_pkg::ADDR_W-1:0] i_address,            // Byte address
  input  wire logic                            i_read,               // Read request
  input  wire logic                            i_write,              // Write request
  input  wire logic [3:0]                      i_byteenable,         // Byte lanes of write
  input  wire logic [line_out_pkg::DATA_W-1:0] i_writedata,          // Write data
  output logic      [line_out_pkg::DATA_W-1:0] o_readdata,           // Read data
  output logic                                 o_waitrequest,        // Stall while high
  output logic                                 o_irq,                // Level interrupt
  input  wire logic                            i_left_dac_up,        // Left DAC powered
  input  wire logic                            i_right_dac_up,       // Right DAC powered
  input  wire logic                            i_left_line_out_up,   // Left line driver powered
  input  wire logic                            i_right_line_out_up,  // Right line driver powered
  input  wire logic                            i_left_hp_out_up,     // Left headphone driver powered
  input  wire logic                            i_right_hp_out_up,    // Right headphone driver powered
  input  wire logic [3:0]                      i_short,              // Shorts: lhp, rhp, lcom, rcom
  input  wire logic                            i_left_common_up,     // Left common driver powered
  input  wire logic                            i_right_common_up,    // Right common driver powered
  output logic      [3:0]                      o_left_line_level,    // Applied left gain code
  output logic                                 o_left_line_unmute,   // Left line output unmuted
  output logic                                 o_left_line_power,    // Left line power control
  output logic      [3:0]                      o_right_line_level,   // Applied right gain code
  output logic                                 o_right_line_unmute,  // Right line output unmuted
  output logic                                 o_right_line_power,   // Right line power control
  output logic      [3:0]                      o_route_enable,       // lgain, ldac, rgain, rdac
  output logic      [27:0]                     o_route_volume        // Four 7-bit codes, slot 0 low
);

  localparam int CNT_W = 16;

  if (STEP_CYCLES < 1 || STEP_CYCLES >= (1 << CNT_W)) begin : g_bad_step
    $error("STEP_CYCLES out of range");
  end

  typedef struct packed {
    logic             ack;
    logic [7:0]       rdata;
    logic [7:0]       left_level;
    logic [7:0]       right_level;
    logic [7:0]       rsvd_a;
    logic [7:0]       rsvd_b;
    logic [3:0][7:0]  route;
    logic [3:0]       left_applied;
    logic [3:0]       right_applied;
    logic             left_pend;
    logic             right_pend;
    logic [CNT_W-1:0] step_cnt;
    logic [3:0]       short_prev;
    logic [7:0]       irq_stat;
    logic [7:0]       irq_mask;
  } regs_state_t;

  regs_state_t state_ff;
  regs_state_t nxt_state;

  logic [line_out_pkg::SYNC_W-1:0] hw_sync;
  logic [7:0]                      power_status;
  logic [7:0]                      short_status;
  logic [6:0]                      req_idx;
  logic                            req_aligned;
  logic                            req_any;
  logic                            wr_fire;
  logic                            step_tick;

  status_sync #(
    .W (line_out_pkg::SYNC_W)
  ) u_status_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   ({i_left_dac_up, i_right_dac_up, i_left_line_out_up, i_right_line_out_up,
                 i_left_hp_out_up, i_right_hp_out_up, i_short, i_left_common_up, i_right_common_up}),
    .o_sync    (hw_sync)
  );

  // Moves the applied gain one code toward the programmed one
  function automatic logic [3:0] step_toward(input logic [3:0] cur, input logic [3:0] tgt);
    logic [3:0] res;
    res = cur;
    if (cur < tgt) begin
      res = cur + 4'h1;
    end else if (cur > tgt) begin
      res = cur - 4'h1;
    end
    return res;
  endfunction

  // Level register as read back: reserved bit forced low, pending bit live
  function automatic logic [7:0] level_view(input logic [7:0] stored, input logic pend);
    logic [7:0] res;
    res                         = stored;
    res[line_out_pkg::RSVD_BIT] = 1'b0;
    res[line_out_pkg::PEND_BIT] = pend;
    return res;
  endfunction

  // Keeps the writable fields of a level register, read-only bits from before
  function automatic logic [7:0] level_write(input logic [7:0] old, input logic [7:0] wd);
    logic [7:0] res;
    res                         = wd;
    res[line_out_pkg::RSVD_BIT] = old[line_out_pkg::RSVD_BIT];
    res[line_out_pkg::PEND_BIT] = old[line_out_pkg::PEND_BIT];
    return res;
  endfunction

  // Status is live: built straight from the synchronised levels
  always_comb begin
    power_status    = 8'h00;
    power_status[7] = hw_sync[11];
    power_status[6] = hw_sync[10];
    power_status[4] = hw_sync[9];
    power_status[3] = hw_sync[8];
    power_status[2] = hw_sync[7];
    power_status[1] = hw_sync[6];
    short_status      = 8'h00;
    short_status[7:4] = hw_sync[5:2];
    short_status[3]   = hw_sync[1];
    short_status[2]   = hw_sync[0];
  end

  assign req_any     = i_read | i_write;
  assign req_idx     = i_address[line_out_pkg::ADDR_W-1:2];
  assign req_aligned = (i_address[1:0] == 2'b00);
  // Write lands on the edge where waitrequest is seen low
  assign wr_fire     = i_write & state_ff.ack & req_aligned & i_byteenable[0];
  assign step_tick   = (state_ff.step_cnt == '0);

  always_comb begin
    logic [7:0] rd;
    logic [7:0] wd;
    logic       left_done;
    logic       right_done;
    logic [7:0] events;
    rd         = 8'h00;
    wd         = i_writedata[7:0];
    left_done  = 1'b0;
    right_done = 1'b0;
    events     = 8'h00;
    nxt_state  = state_ff;

    // One wait state: first cycle captures data, second completes
    nxt_state.ack = req_any & ~state_ff.ack;

    if (!req_aligned) begin
      rd = 8'h00;
    end else if (req_idx == line_out_pkg::IDX_LEFT_LINE_OUT_LEVEL) begin
      rd = level_view(state_ff.left_level, state_ff.left_pend);
    end else if (req_idx == line_out_pkg::IDX_RESERVED_A) begin
      rd = state_ff.rsvd_a;
    end else if (req_idx == line_out_pkg::IDX_LEFT_GAIN_TO_RIGHT_LINE) begin
      rd = state_ff.route[line_out_pkg::SLOT_LEFT_GAIN];
    end else if (req_idx == line_out_pkg::IDX_LEFT_DAC_TO_RIGHT_LINE) begin
      rd = state_ff.route[line_out_pkg::SLOT_LEFT_DAC];
    end else if (req_idx == line_out_pkg::IDX_RESERVED_B) begin
      rd = state_ff.rsvd_b;
    end else if (req_idx == line_out_pkg::IDX_RIGHT_GAIN_TO_RIGHT_LINE) begin
      rd = state_ff.route[line_out_pkg::SLOT_RIGHT_GAIN];
    end else if (req_idx == line_out_pkg::IDX_RIGHT_DAC_TO_RIGHT_LINE) begin
      rd = state_ff.route[line_out_pkg::SLOT_RIGHT_DAC];
    end else if (req_idx == line_out_pkg::IDX_RIGHT_LINE_OUT_LEVEL) begin
      rd = level_view(state_ff.right_level, state_ff.right_pend);
    end else if (req_idx == line_out_pkg::IDX_MODULE_POWER_STATUS) begin
      rd = power_status;
    end else if (req_idx == line_out_pkg::IDX_DRIVER_SHORT_STATUS) begin
      rd = short_status;
    end else if (req_idx == line_out_pkg::IDX_IRQ_STATUS) begin
      rd = state_ff.irq_stat;
    end else if (req_idx == line_out_pkg::IDX_IRQ_MASK) begin
      rd = state_ff.irq_mask;
    end
    if (i_read & ~state_ff.ack) begin
      nxt_state.rdata = rd;
    end

    // Writes; power and short status registers and unmapped words ignore them
    if (wr_fire) begin
      if (req_idx == line_out_pkg::IDX_LEFT_LINE_OUT_LEVEL) begin
        nxt_state.left_level = level_write(state_ff.left_level, wd);
      end else if (req_idx == line_out_pkg::IDX_RESERVED_A) begin
        nxt_state.rsvd_a = wd;
      end else if (req_idx == line_out_pkg::IDX_LEFT_GAIN_TO_RIGHT_LINE) begin
        nxt_state.route[line_out_pkg::SLOT_LEFT_GAIN] = wd;
      end else if (req_idx == line_out_pkg::IDX_LEFT_DAC_TO_RIGHT_LINE) begin
        nxt_state.route[line_out_pkg::SLOT_LEFT_DAC] = wd;
      end else if (req_idx == line_out_pkg::IDX_RESERVED_B) begin
        nxt_state.rsvd_b = wd;
      end else if (req_idx == line_out_pkg::IDX_RIGHT_GAIN_TO_RIGHT_LINE) begin
        nxt_state.route[line_out_pkg::SLOT_RIGHT_GAIN] = wd;
      end else if (req_idx == line_out_pkg::IDX_RIGHT_DAC_TO_RIGHT_LINE) begin
        nxt_state.route[line_out_pkg::SLOT_RIGHT_DAC] = wd;
      end else if (req_idx == line_out_pkg::IDX_RIGHT_LINE_OUT_LEVEL) begin
        nxt_state.right_level = level_write(state_ff.right_level, wd);
      end else if (req_idx == line_out_pkg::IDX_IRQ_MASK) begin
        nxt_state.irq_mask = wd;
      end
    end

    // Gain ramp: a new target re-arms pending at once, so a read never misses it
    if (step_tick) begin
      nxt_state.step_cnt = CNT_W'(STEP_CYCLES - 1);
    end else begin
      nxt_state.step_cnt = state_ff.step_cnt - 1'b1;
    end
    if (step_tick) begin
      nxt_state.left_applied  = step_toward(state_ff.left_applied,
                                            state_ff.left_level[line_out_pkg::LEVEL_MSB:line_out_pkg::LEVEL_LSB]);
      nxt_state.right_applied = step_toward(state_ff.right_applied,
                                            state_ff.right_level[line_out_pkg::LEVEL_MSB:line_out_pkg::LEVEL_LSB]);
    end
    nxt_state.left_pend  = (nxt_state.left_applied !=
                            nxt_state.left_level[line_out_pkg::LEVEL_MSB:line_out_pkg::LEVEL_LSB]) |
                           (state_ff.left_pend & ~step_tick);
    nxt_state.right_pend = (nxt_state.right_applied !=
                            nxt_state.right_level[line_out_pkg::LEVEL_MSB:line_out_pkg::LEVEL_LSB]) |
                           (state_ff.right_pend & ~step_tick);
    left_done  = state_ff.left_pend & ~nxt_state.left_pend;
    right_done = state_ff.right_pend & ~nxt_state.right_pend;

    // Sticky events; a new event beats a clear in the same cycle
    nxt_state.short_prev = short_status[7:4];
    events[7:line_out_pkg::IRQ_SHORT_LSB]  = short_status[7:4] & ~state_ff.short_prev;
    events[line_out_pkg::IRQ_LEFT_DONE]    = left_done;
    events[line_out_pkg::IRQ_RIGHT_DONE]   = right_done;
    nxt_state.irq_stat = state_ff.irq_stat;
    if (wr_fire && req_idx == line_out_pkg::IDX_IRQ_STATUS) begin
      nxt_state.irq_stat = state_ff.irq_stat & ~wd;
    end
    nxt_state.irq_stat = nxt_state.irq_stat | events;

    if (!i_reset_n) begin
      nxt_state               = '0;
      nxt_state.left_level    = line_out_pkg::RESET_BYTE;
      nxt_state.right_level   = line_out_pkg::RESET_BYTE;
      nxt_state.rsvd_a        = line_out_pkg::RESET_BYTE;
      nxt_state.rsvd_b        = line_out_pkg::RESET_BYTE;
      nxt_state.left_pend     = line_out_pkg::RESET_PEND;
      nxt_state.right_pend    = line_out_pkg::RESET_PEND;
      nxt_state.step_cnt      = CNT_W'(STEP_CYCLES - 1);
      nxt_state.short_prev    = 4'h0;
    end
  end

  always_ff @(posedge i_clk) begin
    state_ff <= nxt_state;
  end

  assign o_waitrequest = req_any & ~state_ff.ack;
  assign o_readdata    = {{(line_out_pkg::DATA_W-8){1'b0}}, state_ff.rdata};
  assign o_irq         = |(state_ff.irq_stat & state_ff.irq_mask);

  assign o_left_line_level   = state_ff.left_applied;
  assign o_left_line_unmute  = state_ff.left_level[line_out_pkg::MUTE_BIT];
  assign o_left_line_power   = state_ff.left_level[line_out_pkg::POWER_BIT];
  assign o_right_line_level  = state_ff.right_applied;
  assign o_right_line_unmute = state_ff.right_level[line_out_pkg::MUTE_BIT];
  assign o_right_line_power  = state_ff.right_level[line_out_pkg::POWER_BIT];

  always_comb begin
    for (int s = 0; s < 4; s++) begin
      o_route_enable[s]       = state_ff.route[s][line_out_pkg::ROUTE_BIT];
      o_route_volume[s*7 +: 7] = state_ff.route[s][line_out_pkg::VOL_MSB:0];
    end
  end

endmodule

// ### line_out_routing_status_regs_asserts.sv
/*
  Port-level checks for the line-output register bank, bound to its top module.
  Assumes a bus master that holds each request until waitrequest is sampled low.
*/
module line_out_routing_status_regs_asserts (
  input wire logic        i_clk,                // System clock
  input wire logic        i_reset_n,            // Synchronous reset, active low
  input wire logic [8:0]  i_address,            // Byte address
  input wire logic        i_read,               // Read request
  input wire logic        i_write,              // Write request
  input wire logic [3:0]  i_byteenable,         // Byte lanes
  input wire logic [31:0] i_writedata,          // Write data
  input wire logic [31:0] o_readdata,           // Read data
  input wire logic        o_waitrequest,        // Stall
  input wire logic        o_irq,                // Interrupt
  input wire logic        i_left_dac_up,        // Left DAC powered
  input wire logic        i_right_dac_up,       // Right DAC powered
  input wire logic        i_left_line_out_up,   // Left line driver powered
  input wire logic        i_right_line_out_up,  // Right line driver powered
  input wire logic        i_left_hp_out_up,     // Left headphone powered
  input wire logic        i_right_hp_out_up,    // Right headphone powered
  input wire logic [3:0]  o_left_line_level,    // Applied left gain
  input wire logic        o_left_line_unmute,   // Left unmute
  input wire logic        o_left_line_power,    // Left power
  input wire logic        o_right_line_unmute,  // Right unmute
  input wire logic [3:0]  o_route_enable,       // Route enables
  input wire logic [27:0] o_route_volume        // Route volumes
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  // Status reads only judged once the synchronisers hold post-reset samples
  logic [2:0] up_ff;
  logic [7:0] pwr_exp;
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) up_ff <= 3'h0;
    else if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
  end
  assign pwr_exp = {i_left_dac_up, i_right_dac_up, 1'b0, i_left_line_out_up, i_right_line_out_up,
                    i_left_hp_out_up, i_right_hp_out_up, 1'b0};

  first_wait_a: assert property ($rose(i_read || i_write) |-> o_waitrequest)
    else $error("waitrequest low in first request cycle");
  one_wait_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("more than one wait cycle");
  idle_wait_a: assert property (!(i_read || i_write) |-> !o_waitrequest)
    else $error("waitrequest high while idle");
  rd_upper_a: assert property (i_read && !o_waitrequest |-> o_readdata[31:8] == 24'h0)
    else $error("read data upper bytes not zero");
  unmute_write_a: assert property (
    i_write && !o_waitrequest && i_address == 9'h158 && i_byteenable[0]
    |=> o_left_line_unmute == $past(i_writedata[3]) && o_left_line_power == $past(i_writedata[0]))
    else $error("left mute or power output not taken from write");
  route_write_a: assert property (
    i_write && !o_waitrequest && i_address == 9'h160 && i_byteenable[0]
    |=> o_route_enable[0] == $past(i_writedata[7]) && o_route_volume[6:0] == $past(i_writedata[6:0]))
    else $error("route slot 0 not taken from write");
  mute_hold_a: assert property (
    !$stable(o_right_line_unmute) |-> $past(i_write && !o_waitrequest && i_address == 9'h174))
    else $error("right unmute changed without a write");
  level_step_a: assert property (
    !$stable(o_left_line_level) |-> o_left_line_level == $past(o_left_line_level) + 4'h1
    || o_left_line_level == $past(o_left_line_level) - 4'h1)
    else $error("left level moved by more than one code");
  pwr_status_a: assert property (
    i_read && !o_waitrequest && i_address == 9'h178 && up_ff == 3'h7 && $stable(pwr_exp)
    && $past(pwr_exp, 2) == pwr_exp && $past(pwr_exp, 3) == pwr_exp |-> o_readdata == {24'h0, pwr_exp})
    else $error("power status read does not match inputs");

  cover property (i_read && !o_waitrequest);
  cover property (i_write && !o_waitrequest);
  cover property (o_irq);
  cover property (!$stable(o_left_line_level));
endmodule

bind line_out_routing_status_regs line_out_routing_status_regs_asserts u_chk (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_address(i_address), .i_read(i_read), .i_write(i_write),
  .i_byteenable(i_byteenable), .i_writedata(i_writedata), .o_readdata(o_readdata),
  .o_waitrequest(o_waitrequest), .o_irq(o_irq), .i_left_dac_up(i_left_dac_up),
  .i_right_dac_up(i_right_dac_up), .i_left_line_out_up(i_left_line_out_up),
  .i_right_line_out_up(i_right_line_out_up), .i_left_hp_out_up(i_left_hp_out_up),
  .i_right_hp_out_up(i_right_hp_out_up), .o_left_line_level(o_left_line_level),
  .o_left_line_unmute(o_left_line_unmute), .o_left_line_power(o_left_line_power),
  .o_right_line_unmute(o_right_line_unmute), .o_route_enable(o_route_enable),
  .o_route_volume(o_route_volume));

// ### line_out_routing_status_regs_tb.sv
/*
  Self-checking bench for the line-output register bank.
  Assumes the design package is compiled first; drives the bus and all status levels.
*/
module line_out_routing_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct { logic wr; logic [8:0] a; logic [7:0] wd; logic [7:0] m; logic [7:0] e; } row_t;
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic [8:0]  i_address = 9'h000;
  logic        i_read = 1'b0;
  logic        i_write = 1'b0;
  logic [3:0]  i_byteenable = 4'h1;
  logic [31:0] i_writedata = 32'h0;
  logic [5:0]  pw = 6'h00;  // Powered: ldac, rdac, lline, rline, lhp, rhp
  logic [5:0]  sh = 6'h00;  // Shorts lhp, rhp, lcom, rcom, then lcom up, rcom up
  logic [31:0] o_readdata, rd;
  logic        o_waitrequest, o_irq, o_left_line_unmute, o_left_line_power, o_right_line_unmute, o_right_line_power;
  logic [3:0]  o_left_line_level, o_right_line_level, o_route_enable;
  logic [27:0] o_route_volume;
  int          num_errors = 0;
  int          n_checks = 0;
  // Level rows mask the pending bit, whose timing depends on the ramp; level codes stay 0-9
  row_t rows[12] = '{'{1'b1, 9'h158, 8'h9d, 8'hfd, 8'h99}, '{1'b1, 9'h174, 8'h16, 8'hfd, 8'h10},
    '{1'b1, 9'h160, 8'hff, 8'hff, 8'hff}, '{1'b1, 9'h164, 8'h2a, 8'hff, 8'h2a},
    '{1'b1, 9'h16c, 8'h81, 8'hff, 8'h81}, '{1'b1, 9'h170, 8'h7f, 8'hff, 8'h7f},
    '{1'b0, 9'h15c, 8'h00, 8'hff, 8'h00}, '{1'b0, 9'h168, 8'h00, 8'hff, 8'h00},
    '{1'b1, 9'h178, 8'h9e, 8'hff, 8'h00}, '{1'b1, 9'h17c, 8'hfc, 8'hff, 8'h00},
    '{1'b1, 9'h1f0, 8'hff, 8'hff, 8'h00}, '{1'b1, 9'h15a, 8'hff, 8'hff, 8'h00}};

  line_out_routing_status_regs #(.STEP_CYCLES(8)) uut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_byteenable(i_byteenable), .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .o_irq(o_irq), .i_left_dac_up(pw[5]), .i_right_dac_up(pw[4]),
    .i_left_line_out_up(pw[3]), .i_right_line_out_up(pw[2]), .i_left_hp_out_up(pw[1]),
    .i_right_hp_out_up(pw[0]), .i_short(sh[5:2]), .i_left_common_up(sh[1]), .i_right_common_up(sh[0]),
    .o_left_line_level(o_left_line_level), .o_left_line_unmute(o_left_line_unmute),
    .o_left_line_power(o_left_line_power), .o_right_line_level(o_right_line_level),
    .o_right_line_unmute(o_right_line_unmute), .o_right_line_power(o_right_line_power),
    .o_route_enable(o_route_enable), .o_route_volume(o_route_volume));

  always #50 i_clk = ~i_clk;

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One Avalon transfer; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge i_clk);
    i_address <= a;
    i_write <= w;
    i_read <= !w;
    i_writedata <= {24'h0, d};
    i_byteenable <= be;
    @(posedge i_clk);
    while (o_waitrequest !== 1'b0 && n < 50) begin
      n++;
      @(posedge i_clk);
    end
    if (n == 50) check("waitrequest", 32'h0, {31'h0, o_waitrequest});
    rd = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask

  task automatic reset_check();
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    #1;
    check("outputs after reset", 32'h0, {15'h0, o_left_line_level, o_right_line_level, o_route_enable, o_irq,
      o_left_line_unmute, o_left_line_power, o_right_line_unmute, o_right_line_power});
    check("route volume after reset", 32'h0, {4'h0, o_route_volume});
    for (int k = 'h56; k <= 'h5f; k++) begin
      bus(1'b0, {k[6:0], 2'b00}, 8'h00, 4'h1);
      // The first read lands before the first ramp tick, so left pending still reads one
      check($sformatf("reset value %h", k), (k == 'h56) ? 32'h2 : 32'h0,
        rd & {24'hffffff, (k == 'h5d) ? 8'hfd : 8'hff});
    end
  endtask

  initial begin
    repeat (5000) @(posedge i_clk);
    num_errors++;
    summarize();
  end

  initial begin
    int k;
    reset_check();
    foreach (rows[i]) begin
      if (rows[i].wr) bus(1'b1, rows[i].a, rows[i].wd, 4'h1);
      bus(1'b0, rows[i].a, 8'h00, 4'h1);
      check($sformatf("row %0d", i), {24'h0, rows[i].e}, rd & {24'hffffff, rows[i].m});
    end
    bus(1'b1, 9'h164, 8'h55, 4'h0);
    bus(1'b0, 9'h164, 8'h00, 4'h1);
    check("lane off write", 32'h2a, rd);
    #1;
    check("route enable", 32'h5, {28'h0, o_route_enable});
    check("route volume", {4'h0, 7'h7f, 7'h01, 7'h2a, 7'h7f}, {4'h0, o_route_volume});
    check("line controls", 32'hc, {28'h0, o_left_line_unmute, o_left_line_power,
      o_right_line_unmute, o_right_line_power});
    bus(1'b1, 9'h174, 8'h58, 4'h1);
    bus(1'b0, 9'h174, 8'h00, 4'h1);
    check("pending while ramping", 32'h1, {31'h0, rd[1]});
    k = 0;
    do begin
      bus(1'b0, 9'h174, 8'h00, 4'h1);
      k++;
    end while (rd[1] !== 1'b0 && k < 40);
    check("right level reg", 32'h58, rd);
    bus(1'b0, 9'h158, 8'h00, 4'h1);
    check("left level reg", 32'h99, rd);
    check("applied levels", 32'h95, {24'h0, o_left_line_level, o_right_line_level});
    for (int p = 0; p < 2; p++) begin
      @(posedge i_clk);
      pw <= p ? 6'h2a : 6'h3f;
      sh <= p ? 6'h15 : 6'h3f;
      repeat (4) @(posedge i_clk);
      bus(1'b1, 9'h178, 8'h00, 4'h1);
      bus(1'b0, 9'h178, 8'h00, 4'h1);
      check("power status", {24'h0, pw[5:4], 1'b0, pw[3:0], 1'b0}, rd);
      bus(1'b1, 9'h17c, 8'hfc, 4'h1);
      bus(1'b0, 9'h17c, 8'h00, 4'h1);
      check("short status", {24'h0, sh, 2'b00}, rd);
    end
    bus(1'b0, 9'h180, 8'h00, 4'h1);
    check("irq status", 32'hf3, rd);
    check("irq masked", 32'h0, {31'h0, o_irq});
    bus(1'b1, 9'h184, 8'h80, 4'h1);
    #1 check("irq unmasked", 32'h1, {31'h0, o_irq});
    bus(1'b1, 9'h180, 8'hff, 4'h1);
    bus(1'b0, 9'h180, 8'h00, 4'h1);
    check("irq cleared", 32'h0, {23'h0, o_irq, rd[7:0]});
    sh <= 6'h00;
    repeat (2) @(posedge i_clk);
    sh <= 6'h20;
    repeat (4) @(posedge i_clk);
    bus(1'b0, 9'h180, 8'h00, 4'h1);
    check("short event", 32'h180, {23'h0, o_irq, rd[7:0]});
    bus(1'b1, 9'h184, 8'h00, 4'h1);
    #1 check("irq remasked", 32'h0, {31'h0, o_irq});
    pw <= 6'h00;
    sh <= 6'h00;
    reset_check();
    summarize();
  end
endmodule
